//--- rtl/dap_alarm_map.svh
`ifndef DAP_ALARM_MAP_SVH
`define DAP_ALARM_MAP_SVH
`define DAP_CLK_HZ          50000000
`define DAP_PULSE_US        11
`define DAP_PULSE_CYC       ((`DAP_PULSE_US * `DAP_CLK_HZ + 999999) / 1000000)
`define DAP_BANNER_MS       500
`define DAP_BANNER_CYC      ((`DAP_BANNER_MS * (`DAP_CLK_HZ / 1000)))
`define DAP_HOURS_PER_DAY   24
`define DAP_MIN_PER_HOUR    60
`define DAP_SEC_PER_MIN     60
`define DAP_ALARM_RESET     17'h0_0000
`define DAP_HOUR_LSB        12
`define DAP_MIN_LSB         6
`define DAP_SEC_LSB         0
`endif

//--- rtl/dap_pkg.sv
package dap_pkg;
    typedef enum logic [2:0] {
        DAP_IDLE   = 3'b001,
        DAP_BANNER = 3'b010,
        DAP_SHOW   = 3'b100
    } dap_disp_type;
endpackage : dap_pkg

//--- rtl/dap_counter.sv
module dap_counter #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned LIMIT = 60
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             step,
    output logic      [WIDTH-1:0] count_ff,
    output logic                  wrap
);
    // wraps at LIMIT-1 on step
    assign wrap = step && (count_ff == WIDTH'(LIMIT - 1));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
        end else if (load) begin
            count_ff <= load_val;
        end else if (wrap) begin
            count_ff <= '0;
        end else if (step) begin
            count_ff <= count_ff + WIDTH'(1);
        end
    end
endmodule : dap_counter

//--- rtl/dap_alarm.sv
`include "dap_alarm_map.svh"

module dap_alarm #(
    parameter int unsigned PULSE_CYC  = `DAP_PULSE_CYC,
    parameter int unsigned BANNER_CYC = `DAP_BANNER_CYC,
    parameter int unsigned SEC_CYC    = `DAP_CLK_HZ
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        full_reset,
    input  wire logic        self_test,
    input  wire logic        chain_enter,
    input  wire logic        stand_alone,
    input  wire logic        set_select,
    input  wire logic        digit_valid,
    input  wire logic [3:0]  digit,
    input  wire logic        enter_key,
    input  wire logic        tod_load,
    input  wire logic [16:0] tod_load_val,
    input  wire logic        pin_in,
    output logic             alarm_pin_out,
    output logic             alarm_pin_oe_n,
    output logic             serial_in_ff,
    output logic             banner_ff,
    output logic             show_ff,
    output logic [16:0]      show_val_ff,
    output logic             channel_mode_ff
);
    ////////////////////////////////////////////////////////////////////
    logic [16:0] alarm_ff;
    logic [23:0] digits_ff;
    logic [2:0]  ndig_ff;
    logic        chain_ff;
    logic        pulse_ff;
    logic [$clog2(PULSE_CYC+1)-1:0]  pcnt_ff;
    logic [$clog2(BANNER_CYC+1)-1:0] bcnt_ff;
    logic [$clog2(SEC_CYC+1)-1:0]    tick_cnt_ff;
    logic        sec_tick;
    logic        pin_s1_ff;
    logic [4:0]  tod_h;
    logic [5:0]  tod_m;
    logic [5:0]  tod_s;
    logic        wrap_s;
    logic        wrap_m;
    dap_pkg::dap_disp_type disp_ff;
    dap_pkg::dap_disp_type nxt_disp;

    ////////////////////////////////////////////////////////////////////
    // time of day, seconds resolution
    assign sec_tick = (tick_cnt_ff == ($bits(tick_cnt_ff))'(SEC_CYC - 1));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_ff <= '0;
        end else if (sec_tick || tod_load) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end

    dap_counter #(.WIDTH(6), .LIMIT(`DAP_SEC_PER_MIN)) u_sec (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .load     (tod_load),
        .load_val (tod_load_val[`DAP_SEC_LSB +: 6]),
        .step     (sec_tick),
        .count_ff (tod_s),
        .wrap     (wrap_s)
    );
    dap_counter #(.WIDTH(6), .LIMIT(`DAP_MIN_PER_HOUR)) u_min (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .load     (tod_load),
        .load_val (tod_load_val[`DAP_MIN_LSB +: 6]),
        .step     (wrap_s),
        .count_ff (tod_m),
        .wrap     (wrap_m)
    );
    dap_counter #(.WIDTH(5), .LIMIT(`DAP_HOURS_PER_DAY)) u_hour (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .load     (tod_load),
        .load_val (tod_load_val[`DAP_HOUR_LSB +: 5]),
        .step     (wrap_m),
        .count_ff (tod_h),
        .wrap     ()
    );

    ////////////////////////////////////////////////////////////////////
    // key entry: six digits hh mm ss, enter commits
    logic [6:0]  ent_h_w;
    logic [6:0]  ent_m_w;
    logic [6:0]  ent_s_w;
    logic [4:0]  ent_h;
    logic [5:0]  ent_m;
    logic [5:0]  ent_s;
    logic        ent_ok;
    logic [16:0] ent_val;
    logic        commit;
    // kept wide so 99 cannot alias a legal time
    assign ent_h_w = 7'(digits_ff[23:20]) * 7'd10 + 7'(digits_ff[19:16]);
    assign ent_m_w = 7'(digits_ff[15:12]) * 7'd10 + 7'(digits_ff[11:8]);
    assign ent_s_w = 7'(digits_ff[7:4]) * 7'd10 + 7'(digits_ff[3:0]);
    assign ent_h   = ent_h_w[4:0];
    assign ent_m   = ent_m_w[5:0];
    assign ent_s   = ent_s_w[5:0];
    assign ent_ok  = (ent_h_w < 7'd24) && (ent_m_w < 7'd60) && (ent_s_w < 7'd60);
    assign ent_val = {ent_h, ent_m, ent_s};
    assign commit  = enter_key && (disp_ff == dap_pkg::DAP_SHOW)
                     && (ndig_ff == 3'd6) && ent_ok;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            digits_ff <= '0;
            ndig_ff   <= '0;
        end else if (set_select || commit) begin
            digits_ff <= '0;
            ndig_ff   <= '0;
        end else if (digit_valid && disp_ff == dap_pkg::DAP_SHOW && ndig_ff != 3'd6
                     && digit < 4'd10) begin
            digits_ff <= {digits_ff[19:0], digit};
            ndig_ff   <= ndig_ff + 3'd1;
        end
    end

    // self_test deliberately has no effect here
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_ff <= `DAP_ALARM_RESET;
        end else if (full_reset) begin
            alarm_ff <= `DAP_ALARM_RESET;
        end else if (commit) begin
            alarm_ff <= ent_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display sequencing
    logic banner_done;
    assign banner_done = (bcnt_ff == ($bits(bcnt_ff))'(BANNER_CYC - 1));

    always_comb begin
        nxt_disp = disp_ff;
        unique case (disp_ff)
            dap_pkg::DAP_IDLE:   if (set_select) nxt_disp = dap_pkg::DAP_BANNER;
            dap_pkg::DAP_BANNER: if (banner_done) nxt_disp = dap_pkg::DAP_SHOW;
            dap_pkg::DAP_SHOW:   if (commit) nxt_disp = dap_pkg::DAP_IDLE;
            default:             nxt_disp = dap_pkg::DAP_IDLE;
        endcase
        if (set_select) nxt_disp = dap_pkg::DAP_BANNER;
        if (full_reset) nxt_disp = dap_pkg::DAP_IDLE;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            disp_ff         <= dap_pkg::DAP_IDLE;
            bcnt_ff         <= '0;
            banner_ff       <= 1'b0;
            show_ff         <= 1'b0;
            show_val_ff     <= '0;
            channel_mode_ff <= 1'b1;
        end else begin
            disp_ff         <= nxt_disp;
            bcnt_ff         <= (nxt_disp == dap_pkg::DAP_BANNER && !set_select
                                && disp_ff == dap_pkg::DAP_BANNER) ? bcnt_ff + 1'b1 : '0;
            banner_ff       <= (nxt_disp == dap_pkg::DAP_BANNER);
            show_ff         <= (nxt_disp == dap_pkg::DAP_SHOW);
            show_val_ff     <= full_reset ? `DAP_ALARM_RESET
                               : (commit ? ent_val : alarm_ff);
            channel_mode_ff <= (nxt_disp == dap_pkg::DAP_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin ownership and alarm pulse
    logic match;
    logic fire;
    logic sec_tick_d_ff;
    assign match = ({tod_h, tod_m, tod_s} == alarm_ff) && (alarm_ff != 17'h0_0000);
    assign fire  = match && sec_tick_d_ff && !chain_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_tick_d_ff <= 1'b0;
            chain_ff      <= 1'b0;
            pin_s1_ff     <= 1'b1;
            serial_in_ff  <= 1'b1;
        end else begin
            sec_tick_d_ff <= sec_tick || tod_load;
            pin_s1_ff     <= pin_in;
            serial_in_ff  <= pin_s1_ff;
            if (full_reset) begin
                chain_ff <= 1'b0;
            end else if (chain_enter) begin
                chain_ff <= 1'b1;
            end
        end
    end // stand_alone leaves chain_ff set

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_ff       <= 1'b0;
            pcnt_ff        <= '0;
            alarm_pin_out  <= 1'b1;
            alarm_pin_oe_n <= 1'b1;
        end else begin
            if (fire) begin
                pulse_ff <= 1'b1;
                pcnt_ff  <= '0;
            end else if (pulse_ff) begin
                pcnt_ff  <= pcnt_ff + 1'b1;
                pulse_ff <= (pcnt_ff != ($bits(pcnt_ff))'(PULSE_CYC - 1)) && !chain_ff;
            end
            alarm_pin_out  <= 1'b0;
            alarm_pin_oe_n <= !((fire || (pulse_ff && pcnt_ff != ($bits(pcnt_ff))'(PULSE_CYC - 1)))
                               && !chain_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_zero_no_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
        ($past(alarm_ff) == 17'h0_0000 && alarm_ff == 17'h0_0000) |-> alarm_pin_oe_n)
        else $error("pulse with alarm disabled");
    a_chain_no_drive: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(chain_ff) |-> alarm_pin_oe_n)
        else $error("pin driven in chain mode");
    a_pulse_width: assert property (@(posedge mclk) disable iff (!reset_n)
        (fire && !chain_ff) |=> !alarm_pin_oe_n [*8])
        else $error("alarm pulse too short");
    a_full_reset_clr: assert property (@(posedge mclk) disable iff (!reset_n)
        full_reset |=> alarm_ff == 17'h0_0000)
        else $error("full reset did not clear");
    a_commit_loads: assert property (@(posedge mclk) disable iff (!reset_n)
        (commit && !full_reset) |=> (alarm_ff == $past(ent_val)) && channel_mode_ff)
        else $error("enter did not commit");
    a_one_fire: assert property (@(posedge mclk) disable iff (!reset_n)
        fire |=> !fire)
        else $error("repeated fire in one second");
    a_banner_show: assert property (@(posedge mclk) disable iff (!reset_n)
        (set_select && !full_reset) |=> banner_ff)
        else $error("no banner after select");
    a_selftest_keep: assert property (@(posedge mclk) disable iff (!reset_n)
        (self_test && !full_reset && !commit) |=> $stable(alarm_ff))
        else $error("self test changed alarm");
endmodule : dap_alarm

//--- testbench/dap_instrument.sv
////////////////////////////////////////////////////////////////////////////////
// listener on the shared pin: counts low pulses, keeps the last width
module dap_instrument (
    input  wire logic mclk,
    input  wire logic pin_level,
    output int        pulses,
    output int        width
);
    timeunit 1ns;
    timeprecision 1ns;
    int run = 0;
    initial begin
        pulses = 0;
        width = 0;
    end
    always @(posedge mclk) begin
        if (pin_level === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulses <= pulses + 1;
            width <= run;
            run <= 0;
        end
    end
endmodule : dap_instrument

//--- testbench/dap_alarm_bench.sv
module dap_alarm_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FR = 0, ST = 1, CE = 2, SA = 3, SS = 4, DV = 5, EK = 6, TL = 7;
    localparam logic [16:0] ALM = {5'd14, 6'd45, 6'd0};
    logic        mclk, reset_n, chain_drv, pin_out, pin_oe_n, serial_in, banner, show, chan;
    logic [7:0]  pv;
    logic [3:0]  digit;
    logic [16:0] tod_val, show_val;
    int          fails = 0, tests_run = 0, cycles = 0, pulses, width, p0;
    wire         pin_level = (pin_oe_n === 1'b0) ? pin_out : chain_drv;
    ////////////////////////////////////////////////////////////////////////////
    dap_alarm #(.PULSE_CYC(8), .BANNER_CYC(4), .SEC_CYC(4)) dap_alarm_inst (
        .mclk(mclk), .reset_n(reset_n), .full_reset(pv[FR]), .self_test(pv[ST]),
        .chain_enter(pv[CE]), .stand_alone(pv[SA]), .set_select(pv[SS]),
        .digit_valid(pv[DV]), .digit(digit), .enter_key(pv[EK]), .tod_load(pv[TL]),
        .tod_load_val(tod_val), .pin_in(pin_level), .alarm_pin_out(pin_out),
        .alarm_pin_oe_n(pin_oe_n), .serial_in_ff(serial_in), .banner_ff(banner),
        .show_ff(show), .show_val_ff(show_val), .channel_mode_ff(chan));
    dap_instrument dap_instrument_inst (
        .mclk(mclk), .pin_level(pin_level), .pulses(pulses), .width(width));
    ////////////////////////////////////////////////////////////////////////////
    task check_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit
    task check_word(input string name, input logic [16:0] exp, input logic [16:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word
    task tap(input int k);
        pv[k] <= 1'b1;
        @(posedge mclk);
        pv <= 8'h00;
        @(posedge mclk);
    endtask : tap
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    task program_alarm;
        int n;
        int d[7] = '{1, 4, 4, 5, 0, 0, 9};
        tap(SS);
        check_bit("banner", 1'b1, banner);
        for (n = 0; n < 10 && show !== 1'b1; n++) @(posedge mclk);
        check_bit("show", 1'b1, show);
        for (n = 0; n < 7; n++) begin
            digit <= d[n][3:0];
            tap(DV);
        end
        tap(EK);
        check_word("alarm", ALM, show_val);
        check_bit("channel", 1'b1, chan);
        check_bit("show_off", 1'b0, show);
    endtask : program_alarm
    task fire_twice;
        int k;
        for (k = 0; k < 2; k++) begin
            p0 = pulses;
            tod_val <= {5'd14, 6'd44, 6'd59};
            tap(TL);
            repeat (40) @(posedge mclk);
            check_word("pulses", 17'(p0 + 1), 17'(pulses));
            check_word("width", 17'h0_0008, 17'(width));
        end
        tap(ST);
        check_word("kept", ALM, show_val);
    endtask : fire_twice
    task bad_entry;
        int n;
        int d[6] = '{3, 3, 0, 0, 0, 0};
        tap(SS);
        for (n = 0; n < 10 && show !== 1'b1; n++) @(posedge mclk);
        for (n = 0; n < 6; n++) begin
            digit <= d[n][3:0];
            tap(DV);
        end
        tap(EK);
        check_bit("refused", 1'b1, show);
        check_word("unchanged", ALM, show_val);
    endtask : bad_entry
    task zero_silent;
        tap(FR);
        check_word("cleared", 17'h0_0000, show_val);
        p0 = pulses;
        tod_val <= 17'h0_0000;
        tap(TL);
        repeat (40) @(posedge mclk);
        check_word("no_pulse", 17'(p0), 17'(pulses));
    endtask : zero_silent
    task chain_quiet;
        int n;
        program_alarm();
        tap(CE);
        tap(SA);
        chain_drv <= 1'b0;
        repeat (4) @(posedge mclk);
        check_bit("serial_in", 1'b0, serial_in);
        chain_drv <= 1'b1;
        tod_val <= {5'd14, 6'd44, 6'd59};
        tap(TL);
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            check_bit("oe_n", 1'b1, pin_oe_n);
        end
        tap(FR);
        program_alarm();
        fire_twice();
    endtask : chain_quiet
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        reset_n = 1'b0;
        chain_drv = 1'b1;
        pv = 8'h00;
        digit = 4'h0;
        tod_val = 17'h0_0000;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        check_word("reset_alarm", 17'h0_0000, show_val);
        check_bit("reset_oe_n", 1'b1, pin_oe_n);
        program_alarm();
        fire_twice();
        bad_entry();
        zero_silent();
        chain_quiet();
        final_report();
    end
endmodule : dap_alarm_bench
